// File: design/tmgs_cfg.svh
/*
  Constants for the timer mode, gating and clock-source block: register
  offsets, field positions, reset values and the prescale count.
  Assumes it is included by bare name from the design and the testbench.
*/
`ifndef TMGS_CFG_SVH
`define TMGS_CFG_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define TMGS_OFS_MODE     8'h00
`define TMGS_OFS_RUN      8'h04
`define TMGS_OFS_CLKSEL   8'h08
`define TMGS_OFS_PINCFG   8'h0c
`define TMGS_OFS_CNT0     8'h10
`define TMGS_OFS_CNT1     8'h14

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TMGS_MODE_T0_LSB  0
`define TMGS_MODE_T0_SRC  2
`define TMGS_MODE_T0_GATE 3
`define TMGS_MODE_T1_LSB  4
`define TMGS_MODE_T1_SRC  6
`define TMGS_MODE_T1_GATE 7
`define TMGS_RUN_LSB      0
`define TMGS_FLAG_LSB     4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TMGS_MODE_RST     8'h00
`define TMGS_CNT_RST      16'h0000

// ----------------------------------------------------------------------
// Timing: system clock cycles per divided timer tick
// ----------------------------------------------------------------------
`define TMGS_PRESCALE_DIV 4'hc

`endif

// File: design/tmgs_pkg.sv
/*
  Types for the timer mode, gating and clock-source block.
  Assumes tmgs_cfg.svh is on the include path.
*/
package tmgs_pkg;

  // ----------------------------------------------------------------------
  // Operating mode encoding, shared by both timers
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    TMGS_MODE_13BIT  = 2'b00,
    TMGS_MODE_16BIT  = 2'b01,
    TMGS_MODE_RELOAD = 2'b10,
    TMGS_MODE_IDLE   = 2'b11
  } tmgs_mode_type;

  // ----------------------------------------------------------------------
  // Per-timer control view decoded from the mode control register
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic          gate;
    logic          src;
    tmgs_mode_type mode;
  } tmgs_tctl_type;

  // ----------------------------------------------------------------------
  // Whole state of the block
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]       mode_ctl;
    logic [1:0]       run;
    logic [1:0]       flag;
    logic [1:0]       fast_clk;
    logic [1:0]       pin_pol;
    logic [1:0][15:0] cnt;
    logic [1:0]       pin_prev;
    logic [3:0]       div;
    logic [31:0]      rdata;
    logic             slverr;
  } tmgs_state_type;

endpackage : tmgs_pkg

// File: design/tmgs_timer.sv
/*
  Mode, gating and clock-source logic for two counter/timers, with the
  mode control, run/flag, clock select, pin polarity and count registers
  behind an APB slave.
  Assumes APB signals, count pins and interrupt pins are synchronous to
  pclk, and that the interrupt controller pulses vector_ack on entry.
*/
`timescale 1ns/100ps
`include "tmgs_cfg.svh"

module tmgs_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [1:0]  count_pin,
  input  wire logic        ext_irq_pin_zero,
  input  wire logic        ext_irq_pin_one,
  input  wire logic [1:0]  vector_ack,
  output logic [1:0]       overflow_flag
);

  tmgs_pkg::tmgs_state_type state_reg;
  tmgs_pkg::tmgs_state_type state_next;
  tmgs_pkg::tmgs_tctl_type  tctl [2];
  logic [1:0]               irq_pin;
  logic [1:0]               irq_active;
  logic [1:0]               run_enable;
  logic [1:0]               pin_fall;
  logic [1:0]               inc;
  logic [1:0]               ovf_evt;
  logic [1:0]               cnt_wr;
  logic [1:0][16:0]         stepped;
  logic                     div_tick;
  logic                     addr_ok;
  logic                     wr_access;

  // ----------------------------------------------------------------------
  // Counter step for one increment in the given mode
  // ----------------------------------------------------------------------
  // Returns the overflow flag in bit 16 and the new count below it.
  function automatic logic [16:0] step_count(input logic [15:0] c,
                                             input tmgs_pkg::tmgs_mode_type m);
    logic [16:0] r;
    logic [5:0]  lo5;
    logic [8:0]  hi9;
    r   = {1'b0, c};
    lo5 = {1'b0, c[4:0]} + 6'h01;
    hi9 = {1'b0, c[15:8]} + 9'h001;
    unique case (m)
      tmgs_pkg::TMGS_MODE_13BIT: begin
        // Low five bits act as a prescaler below the high byte
        if (lo5[5]) begin
          r = {hi9[8], hi9[7:0], c[7:5], 5'h00};
        end else begin
          r = {1'b0, c[15:5], lo5[4:0]};
        end
      end
      tmgs_pkg::TMGS_MODE_16BIT: begin
        r = {1'b0, c} + 17'h0_0001;
      end
      tmgs_pkg::TMGS_MODE_RELOAD: begin
        if (c[7:0] == 8'hff) begin
          r = {1'b1, c[15:8], c[15:8]};
        end else begin
          r = {1'b0, c[15:8], c[7:0] + 8'h01};
        end
      end
      tmgs_pkg::TMGS_MODE_IDLE: begin
        r = {1'b0, c};
      end
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Mode field decode, gating and count sources
  // ----------------------------------------------------------------------
  assign tctl[0] = state_reg.mode_ctl[`TMGS_MODE_T0_GATE:`TMGS_MODE_T0_LSB];
  assign tctl[1] = state_reg.mode_ctl[`TMGS_MODE_T1_GATE:`TMGS_MODE_T1_LSB];
  assign irq_pin = {ext_irq_pin_one, ext_irq_pin_zero};
  assign div_tick = (state_reg.div == 4'h0);
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= `TMGS_OFS_CNT1);
  assign wr_access = psel && penable && pwrite && clk_en && addr_ok;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_timer
      // Pin polarity bit 1 means the pin is active high
      assign irq_active[g] = (irq_pin[g] == state_reg.pin_pol[g]);
      assign run_enable[g] = state_reg.run[g] &&
                             (!tctl[g].gate || irq_active[g]);
      assign pin_fall[g] = state_reg.pin_prev[g] && !count_pin[g];
      assign inc[g] = run_enable[g] && (tctl[g].src ? pin_fall[g]
                      : (state_reg.fast_clk[g] || div_tick));
      assign stepped[g] = step_count(state_reg.cnt[g], tctl[g].mode);
      assign ovf_evt[g] = inc[g] && stepped[g][16];
      assign cnt_wr[g] = wr_access &&
                         (paddr == (g == 0 ? `TMGS_OFS_CNT0 : `TMGS_OFS_CNT1));
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (clk_en) begin
      state_next.pin_prev = count_pin;
      state_next.div = div_tick ? (`TMGS_PRESCALE_DIV - 4'h1) : (state_reg.div - 4'h1);
      for (int i = 0; i < 2; i++) begin
        if (inc[i]) begin
          state_next.cnt[i] = stepped[i][15:0];
        end
        // A bus write of the count wins over a same-cycle increment
        if (cnt_wr[i]) begin
          state_next.cnt[i] = pwdata[15:0];
        end
        if (vector_ack[i]) begin
          state_next.flag[i] = 1'b0;
        end
      end
      if (wr_access) begin
        unique case (paddr)
          `TMGS_OFS_MODE:   state_next.mode_ctl = pwdata[7:0];
          `TMGS_OFS_RUN: begin
            state_next.run  = pwdata[`TMGS_RUN_LSB +: 2];
            state_next.flag = pwdata[`TMGS_FLAG_LSB +: 2];
          end
          `TMGS_OFS_CLKSEL: state_next.fast_clk = pwdata[1:0];
          `TMGS_OFS_PINCFG: state_next.pin_pol = pwdata[1:0];
          default: ;
        endcase
      end
      // Hardware set wins over a software or vector clear
      state_next.flag = state_next.flag | ovf_evt;
      // Read data and error are latched in the setup phase
      if (psel && !penable) begin
        state_next.slverr = !addr_ok;
        state_next.rdata = 32'h0000_0000;
        unique case (paddr)
          `TMGS_OFS_MODE:   state_next.rdata = {24'h00_0000, state_reg.mode_ctl};
          `TMGS_OFS_RUN:    state_next.rdata = {26'h000_0000, state_reg.flag,
                                                2'b00, state_reg.run};
          `TMGS_OFS_CLKSEL: state_next.rdata = {30'h0000_0000, state_reg.fast_clk};
          `TMGS_OFS_PINCFG: state_next.rdata = {30'h0000_0000, state_reg.pin_pol};
          `TMGS_OFS_CNT0:   state_next.rdata = {16'h0000, state_reg.cnt[0]};
          `TMGS_OFS_CNT1:   state_next.rdata = {16'h0000, state_reg.cnt[1]};
          default:          state_next.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '{mode_ctl: `TMGS_MODE_RST,
                     cnt:      {`TMGS_CNT_RST, `TMGS_CNT_RST},
                     div:      4'h0,
                     rdata:    32'h0000_0000,
                     default:  '0};
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Wait states only while the clock enable is low, so state stays frozen
  // Limitation: a setup phase under a low clock enable latches no read data
  assign pready = clk_en;
  assign prdata = state_reg.rdata;
  assign pslverr = state_reg.slverr;
  assign overflow_flag = state_reg.flag;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_t1_internal_src: assert property (
    clk_en && run_enable[1] && !tctl[1].src && state_reg.fast_clk[1] |-> inc[1])
    else $error("Timer 1 missed an internal clock increment");

  a_t1_pin_src: assert property (
    clk_en && tctl[1].src && count_pin[1] ##1 !count_pin[1] && tctl[1].src && run_enable[1]
    |-> inc[1])
    else $error("Timer 1 missed a pin falling edge");

  a_t1_pin_no_rise: assert property (
    tctl[1].src && !state_reg.pin_prev[1] |-> !inc[1])
    else $error("Timer 1 counted without a falling edge");

  a_mode13_wrap: assert property (
    clk_en && inc[1] && tctl[1].mode == tmgs_pkg::TMGS_MODE_13BIT && !cnt_wr[1]
    && state_reg.cnt[1][15:8] == 8'hff && state_reg.cnt[1][4:0] == 5'h1f
    |=> state_reg.flag[1] && state_reg.cnt[1][15:8] == 8'h00
    && state_reg.cnt[1][4:0] == 5'h00)
    else $error("13-bit mode did not wrap with overflow");

  a_mode16_count: assert property (
    clk_en && inc[1] && tctl[1].mode == tmgs_pkg::TMGS_MODE_16BIT && !cnt_wr[1]
    |=> state_reg.cnt[1] == $past(state_reg.cnt[1]) + 16'h0001)
    else $error("16-bit mode did not advance by one");

  a_mode8_reload: assert property (
    clk_en && inc[1] && tctl[1].mode == tmgs_pkg::TMGS_MODE_RELOAD && !cnt_wr[1]
    && state_reg.cnt[1][7:0] == 8'hff
    |=> state_reg.cnt[1][7:0] == $past(state_reg.cnt[1][15:8]) && state_reg.flag[1])
    else $error("Auto-reload mode did not reload from high byte");

  a_mode_idle_hold: assert property (
    clk_en && tctl[1].mode == tmgs_pkg::TMGS_MODE_IDLE && !cnt_wr[1]
    |-> !ovf_evt[1] ##1 $stable(state_reg.cnt[1]))
    else $error("Idle mode changed the count");

  a_t0_gate_free: assert property (
    !tctl[0].gate && state_reg.run[0] |-> run_enable[0])
    else $error("Timer 0 gated although gate bit is clear");

  a_t0_gate_pin: assert property (
    tctl[0].gate && !irq_active[0] |-> !inc[0])
    else $error("Timer 0 counted with its pin inactive");

  a_t0_internal_src: assert property (
    clk_en && run_enable[0] && !tctl[0].src && div_tick |-> inc[0])
    else $error("Timer 0 missed a divided tick");

  a_t0_pin_src: assert property (
    tctl[0].src && inc[0] |-> state_reg.pin_prev[0] && !count_pin[0])
    else $error("Timer 0 counted without a pin fall");

  a_t1_gate_pin: assert property (
    tctl[1].gate && state_reg.run[1] |-> run_enable[1] == irq_active[1])
    else $error("Timer 1 gate does not follow pin 1");

  a_run_write: assert property (
    wr_access && paddr == `TMGS_OFS_RUN && pwdata[`TMGS_RUN_LSB]
    |=> state_reg.run[0])
    else $error("Run bit write did not enable timer 0");

  a_flag_set_wins: assert property (
    clk_en && ovf_evt[0] |=> state_reg.flag[0] [*1])
    else $error("Overflow flag lost on overflow");

  a_flag_vector_clr: assert property (
    clk_en && vector_ack[1] && !ovf_evt[1] && !wr_access |=> !state_reg.flag[1])
    else $error("Vector entry did not clear overflow flag");

  a_t0_mode_field: assert property (
    tctl[0].mode == tmgs_pkg::tmgs_mode_type'(state_reg.mode_ctl[1:0]))
    else $error("Timer 0 mode does not follow the low mode bits");

  a_ovf_wrap: assert property (
    clk_en && ovf_evt[0] && !cnt_wr[0] && tctl[0].mode == tmgs_pkg::TMGS_MODE_16BIT
    |=> state_reg.cnt[0] == 16'h0000)
    else $error("16-bit overflow did not wrap to zero");

  a_t1_div_src: assert property (
    clk_en && run_enable[1] && !tctl[1].src && div_tick |-> inc[1])
    else $error("Timer 1 missed a divided tick");

  a_t1_src_idle: assert property (
    !tctl[1].src && !state_reg.fast_clk[1] && !div_tick |-> !inc[1])
    else $error("Timer 1 counted between divided ticks");

  a_t0_fast_src: assert property (
    clk_en && run_enable[0] && !tctl[0].src && state_reg.fast_clk[0] |-> inc[0])
    else $error("Timer 0 missed an internal clock increment");

  a_t0_pin_fall: assert property (
    clk_en && tctl[0].src && run_enable[0] && state_reg.pin_prev[0] && !count_pin[0]
    |-> inc[0])
    else $error("Timer 0 missed a pin falling edge");

  a_t1_gate_free: assert property (
    !tctl[1].gate && state_reg.run[1] |-> run_enable[1])
    else $error("Timer 1 gated although gate bit is clear");

  a_run_clear: assert property (
    wr_access && paddr == `TMGS_OFS_RUN && !pwdata[`TMGS_RUN_LSB + 1]
    |=> !state_reg.run[1])
    else $error("Run bit write of 0 did not stop timer 1");

  a_flag_sw_clear: assert property (
    wr_access && paddr == `TMGS_OFS_RUN && !pwdata[`TMGS_FLAG_LSB] && !ovf_evt[0]
    |=> !state_reg.flag[0])
    else $error("Software write of 0 did not clear overflow flag");

  a_flag_sticky: assert property (
    clk_en && state_reg.flag[1] && !vector_ack[1] && !wr_access |=> state_reg.flag[1])
    else $error("Overflow flag dropped without a clear");

  a_t0_idle_hold: assert property (
    clk_en && tctl[0].mode == tmgs_pkg::TMGS_MODE_IDLE && !cnt_wr[0]
    |-> !ovf_evt[0] ##1 $stable(state_reg.cnt[0]))
    else $error("Timer 0 idle mode changed the count");

  a_t0_reload: assert property (
    clk_en && inc[0] && tctl[0].mode == tmgs_pkg::TMGS_MODE_RELOAD && !cnt_wr[0]
    && state_reg.cnt[0][7:0] == 8'hff
    |=> state_reg.cnt[0][7:0] == $past(state_reg.cnt[0][15:8]) && state_reg.flag[0])
    else $error("Timer 0 auto-reload did not reload from high byte");

  a_mode13_carry: assert property (
    clk_en && inc[0] && tctl[0].mode == tmgs_pkg::TMGS_MODE_13BIT && !cnt_wr[0]
    && state_reg.cnt[0][4:0] != 5'h1f
    |=> state_reg.cnt[0][15:5] == $past(state_reg.cnt[0][15:5]))
    else $error("13-bit mode carried before the low five bits wrapped");

  a_mode13_no_ovf: assert property (
    inc[0] && tctl[0].mode == tmgs_pkg::TMGS_MODE_13BIT
    && state_reg.cnt[0][15:8] != 8'hff |-> !ovf_evt[0])
    else $error("13-bit mode overflowed below the top count");

  a_reload_no_ovf: assert property (
    inc[1] && tctl[1].mode == tmgs_pkg::TMGS_MODE_RELOAD
    && state_reg.cnt[1][7:0] != 8'hff |-> !ovf_evt[1])
    else $error("Auto-reload mode overflowed below the top count");

  c_t1_reload: cover property (
    ovf_evt[1] && tctl[1].mode == tmgs_pkg::TMGS_MODE_RELOAD);
  c_t0_gated_pin: cover property (
    tctl[0].gate && inc[0] && tctl[0].src);
  c_flag_race: cover property (ovf_evt[0] && vector_ack[0]);
  c_bus_error: cover property (psel && penable && pslverr);
  c_clk_freeze: cover property (!clk_en && run_enable[0]);

endmodule // tmgs_timer

// File: tb/tmgs_pin_model.sv
/*
  Far-side model of the two external count pins of the timer block.
  Assumes one request at a time from the bench, held until busy rises.
*/
`timescale 1ns/100ps

module tmgs_pin_model (
  input  wire logic       pclk,
  input  wire logic       req,
  input  wire logic       idx,
  input  wire logic [2:0] nfall,
  input  wire logic [2:0] gap,
  output logic [1:0]      count_pin,
  output logic            busy
);
  // ----------------------------------------------------------------------
  // Pulse train
  // ----------------------------------------------------------------------
  // Pins idle high as with a pull-up, so every burst opens with a fall
  initial begin
    count_pin = 2'b11;
    busy      = 1'b0;
    forever begin
      @(posedge pclk);
      if (req === 1'b1) begin
        busy <= 1'b1;
        for (int k = 0; k < nfall; k++) begin
          count_pin[idx] <= 1'b0;
          repeat (gap) @(posedge pclk);
          count_pin[idx] <= 1'b1;
          repeat (gap) @(posedge pclk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule // tmgs_pin_model

// File: tb/tmgs_timer_tb.sv
/*
  Self-checking bench for the timer mode, gating and source block.
  Assumes tmgs_cfg.svh on the include path; APB reads are checked by a
  monitor against notes queued by the driver.
*/
`timescale 1ns/100ps
`include "tmgs_cfg.svh"

module tmgs_timer_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        req, idx, busy, clk_en;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, seed;
  logic [1:0]  count_pin, ext, vack, oflag;
  logic [2:0]  gap, nfall;
  logic [34:0] q[$];
  logic [34:0] exp_v;
  int          failures, n_tests;

  tmgs_timer dut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .count_pin(count_pin), .ext_irq_pin_zero(ext[0]),
    .ext_irq_pin_one(ext[1]), .vector_ack(vack), .overflow_flag(oflag));

  tmgs_pin_model pins (
    .pclk(pclk), .req(req), .idx(idx), .nfall(nfall), .gap(gap),
    .count_pin(count_pin), .busy(busy));

  always #2 pclk = ~pclk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic end_sim();
    if (failures == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Expected read note is {overflow_flag, pslverr, prdata}
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [34:0] e);
    int k;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    if (!w) q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
    if (k == 50) begin
      failures++;
      $display("[FAIL] pready exp 1 got %b", pready);
    end
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic falls(input logic i, input logic [2:0] n);
    int k;
    idx <= i; nfall <= n; gap <= 3'(xs() % 4 + 1); req <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (busy !== 1'b1 && k < 20);
    req <= 1'b0;
    k = 0;
    do begin @(posedge pclk); k++; end while (busy !== 1'b0 && k < 200);
    if (busy !== 1'b0) begin
      failures++;
      $display("[FAIL] pin burst busy exp 0 got %b", busy);
    end
  endtask

  // ----------------------------------------------------------------------
  // Read monitor
  // ----------------------------------------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      exp_v = q.pop_front();
      n_tests++;
      if ({oflag, pslverr, prdata} !== exp_v) begin
        failures++;
        $display("[FAIL] read at %h exp %h got %h", paddr, exp_v, {oflag, pslverr, prdata});
      end
    end
  end

  // Whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    $display("[FAIL] watchdog exp done got timeout");
    end_sim();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [15:0] init, expc;
    logic [1:0]  of;
    logic [31:0] v;
    seed = 32'd95034; pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; ext = 2'b11; vack = 0; req = 0; idx = 0; nfall = 0; gap = 1;
    failures = 0; n_tests = 0;
    clk_en = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `TMGS_OFS_MODE, 0, 35'h0);
    apb(1, 8'h18, 32'hffff_ffff, 35'h0);
    apb(0, 8'h18, 0, {3'b001, 32'h0});
    apb(1, 8'h02, 32'hffff_ffff, 35'h0);
    apb(0, 8'h02, 0, {3'b001, 32'h0});
    v = xs() & 32'h0000_00ff;
    apb(1, `TMGS_OFS_MODE, v, 35'h0);
    apb(0, `TMGS_OFS_MODE, 0, {3'b000, v});
    // Gate pins stay inactive here, so gate 0 must count on run alone
    for (int i = 0; i < 2; i++) begin
      for (int m = 0; m < 4; m++) begin
        init = (m == 2) ? 16'h40fe : (m == 3) ? 16'h1234 : 16'hfffe;
        expc = (m == 0) ? 16'h00e1 : (m == 1) ? 16'h0001 : (m == 2) ? 16'h4041 : 16'h1234;
        of   = (m != 3) ? 2'(1 << i) : 2'b00;
        apb(1, `TMGS_OFS_MODE, 32'(4 + m) << (4 * i), 35'h0);
        apb(1, `TMGS_OFS_CNT0 + 8'(4 * i), {16'h0, init}, 35'h0);
        apb(1, `TMGS_OFS_RUN, 32'(1 << i), 35'h0);
        falls(i[0], 3'd3);
        apb(0, `TMGS_OFS_CNT0 + 8'(4 * i), 0, {of, 17'h0, expc});
        apb(0, `TMGS_OFS_RUN, 0, {of, 1'b0, 32'(1 << i) | (32'(of) << 4)});
        vack <= 2'(1 << i);
        @(posedge pclk);
        vack <= 2'b00;
        apb(0, `TMGS_OFS_RUN, 0, {3'b000, 32'(1 << i)});
      end
    end
    // Gate 1 with either pin polarity, fast and divided internal clock
    for (int i = 0; i < 2; i++) begin
      for (int p = 0; p < 2; p++) begin
        for (int f = 0; f < 2; f++) begin
          ext[i] <= ~p[0];
          apb(1, `TMGS_OFS_PINCFG, (p == 1) ? 32'h3 : 32'h0, 35'h0);
          apb(1, `TMGS_OFS_CLKSEL, (f == 1) ? 32'h3 : 32'h0, 35'h0);
          apb(1, `TMGS_OFS_MODE, 32'h9 << (4 * i), 35'h0);
          apb(1, `TMGS_OFS_CNT0 + 8'(4 * i), 32'h0, 35'h0);
          apb(1, `TMGS_OFS_RUN, 32'(1 << i), 35'h0);
          repeat (20) @(posedge pclk);
          ext[i] <= p[0];
          repeat (3) @(posedge pclk);
          // Frozen cycles must neither count nor advance the divider
          clk_en <= 1'b0;
          repeat (2 + xs() % 6) @(posedge pclk);
          clk_en <= 1'b1;
          repeat ((f == 1) ? 4 : 21) @(posedge pclk);
          ext[i] <= ~p[0];
          apb(0, `TMGS_OFS_CNT0 + 8'(4 * i), 0, (f == 1) ? 35'd7 : 35'd2);
        end
      end
    end
    // A reset in mid-run must clear the timer 1 count, run bits and flags at once
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `TMGS_OFS_CNT1, 0, 35'h0);
    apb(0, `TMGS_OFS_RUN, 0, 35'h0);
    repeat (4) @(posedge pclk);
    if (q.size() != 0) begin
      failures++;
      $display("[FAIL] read queue exp 0 got %0d", q.size());
    end
    end_sim();
  end
endmodule // tmgs_timer_tb
